// *** omc_pkg.sv ***
package omc_pkg;
  // register map, byte addresses on the bus
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CMD = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_PAGE = 4'hC;
  // control word fields
  localparam int CTRL_PS_LSB = 0;
  localparam int CTRL_FC_LSB = 2;
  // command word bits, write-one pulses
  localparam int CMD_SWITCH_OFF = 0;
  localparam int CMD_CALL_START = 1;
  localparam int CMD_CALL_END = 2;
  // status word fields
  localparam int STAT_AVAIL = 3;
  localparam int STAT_CTS = 4;
  localparam int STAT_FAST = 5;
  localparam int STAT_WAKE_LSB = 8;
  // power_saving_setting values
  localparam logic [1:0] PS_DISABLED = 2'h0;
  localparam logic [1:0] PS_PERIODIC = 2'h1;
  localparam logic [1:0] PS_RTS = 2'h2;
  localparam logic [1:0] PS_DTR = 2'h3;
  // flow_control_setting values and reset values
  localparam logic [1:0] FC_OFF = 2'h3;
  localparam logic [1:0] FC_RESET = 2'h0;
  localparam logic [15:0] PAGE_RESET = 16'h0800;
  // wake source positions
  localparam int WK_PAGE = 0;
  localparam int WK_ALARM = 1;
  localparam int WK_UART = 2;
  localparam int WK_RTS = 3;
  localparam int WK_DTR = 4;
  localparam int WK_USBDET = 5;
  localparam int WK_USBRW = 6;
  localparam int WK_AUX = 7;
  localparam int WK_N = 8;
  // synchronised pin positions
  localparam int P_SUPPLY = 0;
  localparam int P_SWON = 1;
  localparam int P_RST_N = 2;
  localparam int P_RTS = 3;
  localparam int P_DTR = 4;
  localparam int P_USBDET = 5;
  localparam int P_USBRW = 6;
  localparam int P_AUX = 7;
  localparam int P_SLOWREF = 8;
  localparam int P_RXD = 9;
  localparam int P_N = 10;
  // timing
  localparam int CLK_MHZ = 25;
  localparam int IDLE_HOLD_US = 10;
  localparam int IDLE_HOLD_CYC = IDLE_HOLD_US * CLK_MHZ;
  // modes, gray steps along not-powered-active-connected/idle
  typedef enum logic [2:0] {
    M_NOPWR = 3'h0,
    M_ACTIVE = 3'h1,
    M_CONN = 3'h3,
    M_IDLE = 3'h5,
    M_OFF = 3'h4
  } omc_mode_t;
endpackage : omc_pkg

// *** omc_mode_ctrl.sv ***
`timescale 1ns/10ps
// Operation
// - switch-off in active goes to power-off
// - power-on, reset or alarm wake power-off
// - supply loss in power-off gives not-powered
// - idle keeps application interfaces unavailable
// - power saving enabled enters idle automatically
// - power saving disabled after every switch-on
// - clear-to-send shows uart enabled or disabled
// - idle wakes periodically for paging
// - setting one wakes periodically with uart
// - alarm in idle wakes to active
// - uart data wakes per flow/saving settings
// - rts on wakes with flow off, setting two
// - dtr on wakes with setting three
// - usb presence sense wakes from idle
// - usb remote wakeup leaves idle
// - aux pin data-ready wakes the device
// - any switch-on event reaches active mode
// - call start in active enters connected
// - call end returns connected to active
// - active/connected keep interfaces unless saving
// - not-powered ignores all but supply
// - idle slow clock, active/connected fast clock
module omc_mode_ctrl #(
  parameter bit INTERNAL_OSC = 1'b1,
  parameter int IDLE_HOLD = omc_pkg::IDLE_HOLD_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [omc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [omc_pkg::DATA_W-1:0] avs_writedata,
  output logic [omc_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic mainSupplyOk,
  input wire logic switchOnLine,
  input wire logic extReset_n,
  input wire logic rtsOn,
  input wire logic dtrOn,
  input wire logic usbPresenceSense,
  input wire logic usbRemoteWake,
  input wire logic auxWakePin,
  input wire logic slowClockInput,
  input wire logic uartRxd,
  input wire logic rtcAlarm,
  output omc_pkg::omc_mode_t mode,
  output logic ifaceAvail,
  output logic ctsOn,
  output logic fastClkSel,
  output logic rtcRun
);
  import omc_pkg::*;

  generate
    if (IDLE_HOLD < 1 || IDLE_HOLD > 65535) begin : g_bad_hold
      $error("IDLE_HOLD must be 1..65535");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; stage one feeds stage two only
  logic [P_N-1:0] pinRaw;
  logic [P_N-1:0] pinMeta;
  logic [P_N-1:0] pinSync;
  logic [P_N-1:0] pinLast;
  assign pinRaw = {uartRxd, slowClockInput, auxWakePin, usbRemoteWake,
                   usbPresenceSense, dtrOn, rtsOn, extReset_n,
                   switchOnLine, mainSupplyOk};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta <= 10'h3FF;
      pinSync <= 10'h3FF;
      pinLast <= 10'h3FF;
    end else begin
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
      pinLast <= pinSync;
    end
  end

  wire [P_N-1:0] pinRise = pinSync & ~pinLast;
  wire [P_N-1:0] pinFall = ~pinSync & pinLast;
  wire supplyOk = pinSync[P_SUPPLY];
  wire supplyUp = pinRise[P_SUPPLY];
  // external slow reference sensed by its own toggling
  wire slowRefEdge = pinRise[P_SLOWREF];

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait state, then a one-cycle answer
  logic [1:0] psSet;
  logic [1:0] fcSet;
  logic [15:0] pagePeriod;
  logic [WK_N-1:0] lastWake;
  logic uartEn;
  logic slowOk;
  logic [7:0] slowWatch;

  wire busReq = avs_read | avs_write;
  wire busDone = busReq & ~avs_waitrequest;
  wire wrCtrl = avs_write & busDone & (avs_address == OFS_CTRL);
  wire wrCmd = avs_write & busDone & (avs_address == OFS_CMD);
  wire wrPage = avs_write & busDone & (avs_address == OFS_PAGE);
  wire cmdOff = wrCmd & avs_writedata[CMD_SWITCH_OFF];
  wire cmdCallOn = wrCmd & avs_writedata[CMD_CALL_START];
  wire cmdCallEnd = wrCmd & avs_writedata[CMD_CALL_END];

  wire [DATA_W-1:0] ctrlWord = {28'h0, fcSet, psSet};
  wire [DATA_W-1:0] statWord = {16'h0, lastWake, 2'h0, fastClkSel,
                                ctsOn, ifaceAvail, mode};
  wire [DATA_W-1:0] pageWord = {16'h0, pagePeriod};
  // unmapped and write-only offsets read as zero
  wire [DATA_W-1:0] rdMux =
    (avs_address == OFS_CTRL) ? ctrlWord :
    (avs_address == OFS_STATUS) ? statWord :
    (avs_address == OFS_PAGE) ? pageWord : 32'h0;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      avs_waitrequest <= ~(busReq & avs_waitrequest);
      avs_readdata <= (avs_read & avs_waitrequest) ? rdMux : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake sources, all evaluated side by side
  logic [15:0] pageCnt;
  logic [15:0] holdCnt;
  wire inIdle = (mode == M_IDLE);
  wire [WK_N-1:0] wakeSrc;
  assign wakeSrc[WK_PAGE] = inIdle & (pageCnt == 16'h0);
  assign wakeSrc[WK_ALARM] = rtcAlarm;
  // rx start bit, masked when rts is the chosen wake path
  assign wakeSrc[WK_UART] = pinFall[P_RXD] &
    ~(psSet == PS_RTS && fcSet == FC_OFF);
  assign wakeSrc[WK_RTS] = pinRise[P_RTS] &
    (psSet == PS_RTS) & (fcSet == FC_OFF);
  assign wakeSrc[WK_DTR] = pinRise[P_DTR] & (psSet == PS_DTR);
  assign wakeSrc[WK_USBDET] = pinRise[P_USBDET];
  assign wakeSrc[WK_USBRW] = pinRise[P_USBRW];
  assign wakeSrc[WK_AUX] = pinRise[P_AUX];
  wire anyWake = |wakeSrc;
  wire hostWake = |(wakeSrc & ~(8'h1 << WK_PAGE));

  // power-off wake events
  wire onEvent = pinRise[P_SWON] | pinFall[P_RST_N] | rtcAlarm;
  // idle allowed only with saving on and a live slow reference
  wire idleGo = (psSet != PS_DISABLED) & slowOk & (holdCnt == 16'h0) &
    ~anyWake & ~busReq;

  ////////////////////////////////////////////////////////////////////////////
  // mode machine
  omc_mode_t next_mode;
  always_comb begin
    next_mode = mode;
    case (mode)
      M_NOPWR: begin
        if (supplyUp) next_mode = M_ACTIVE;
      end
      M_OFF: begin
        if (!supplyOk) next_mode = M_NOPWR;
        else if (onEvent) next_mode = M_ACTIVE;
      end
      M_ACTIVE: begin
        if (!supplyOk) next_mode = M_NOPWR;
        else if (cmdOff) next_mode = M_OFF;
        else if (cmdCallOn) next_mode = M_CONN;
        else if (idleGo) next_mode = M_IDLE;
      end
      M_CONN: begin
        if (!supplyOk) next_mode = M_NOPWR;
        else if (cmdCallEnd) next_mode = M_ACTIVE;
      end
      M_IDLE: begin
        if (!supplyOk) next_mode = M_NOPWR;
        else if (anyWake) next_mode = M_ACTIVE;
      end
      default: next_mode = M_NOPWR;
    endcase
  end

  wire switchOn = (next_mode == M_ACTIVE) &
    ((mode == M_OFF) | (mode == M_NOPWR));
  wire leaveIdle = inIdle & (next_mode == M_ACTIVE);

  // uart enable: always with saving off, per wake cause otherwise
  logic next_uartEn;
  always_comb begin
    next_uartEn = uartEn;
    if (switchOn || psSet == PS_DISABLED) next_uartEn = 1'b1;
    else if (leaveIdle)
      next_uartEn = hostWake | (psSet == PS_PERIODIC);
    else if (inIdle || next_mode == M_IDLE) next_uartEn = 1'b0;
    else if (hostWake) next_uartEn = 1'b1;
  end

  wire next_live = (next_mode == M_ACTIVE) | (next_mode == M_CONN);
  wire next_avail = next_live & next_uartEn;

  // slow reference watchdog: stale after 255 fast cycles
  wire slowSeen = INTERNAL_OSC | (slowWatch != 8'h0);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= M_NOPWR;
      uartEn <= 1'b0;
      ifaceAvail <= 1'b0;
      ctsOn <= 1'b0;
      fastClkSel <= 1'b0;
      rtcRun <= 1'b0;
      slowOk <= 1'b0;
      slowWatch <= 8'h0;
    end else begin
      mode <= next_mode;
      uartEn <= next_uartEn;
      ifaceAvail <= next_avail;
      ctsOn <= next_avail;
      fastClkSel <= next_live;
      slowWatch <= slowRefEdge ? 8'hFF :
        (slowWatch != 8'h0) ? slowWatch - 8'h1 : 8'h0;
      slowOk <= slowSeen;
      rtcRun <= slowSeen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // settings and timers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      psSet <= PS_DISABLED;
      fcSet <= FC_RESET;
      pagePeriod <= PAGE_RESET;
      lastWake <= 8'h0;
    end else begin
      // a switch-on beats a same-cycle write of the setting
      if (switchOn) psSet <= PS_DISABLED;
      else if (wrCtrl) psSet <= avs_writedata[CTRL_PS_LSB +: 2];
      if (wrCtrl) fcSet <= avs_writedata[CTRL_FC_LSB +: 2];
      if (wrPage) pagePeriod <= avs_writedata[15:0];
      if (leaveIdle) lastWake <= wakeSrc;
    end
  end

  // paging interval runs only while idle; zero period wakes at once
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pageCnt <= PAGE_RESET;
      holdCnt <= 16'(IDLE_HOLD);
    end else begin
      pageCnt <= (inIdle && pageCnt != 16'h0) ? pageCnt - 16'h1 :
        pagePeriod;
      // quiet time before idle, restarted by any activity
      holdCnt <= (mode != M_ACTIVE || anyWake || busReq) ?
        16'(IDLE_HOLD) :
        (holdCnt != 16'h0) ? holdCnt - 16'h1 : 16'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_off_interfaces:
    assert property ((mode == M_OFF || mode == M_NOPWR) |-> !ifaceAvail)
    else $error("interfaces available while switched off");
  a_switch_off:
    assert property (mode == M_ACTIVE && supplyOk && cmdOff
                     |=> mode == M_OFF)
    else $error("switch-off did not reach power-off");
  a_off_wake:
    assert property (mode == M_OFF && supplyOk && onEvent
                     |=> mode == M_ACTIVE && fastClkSel)
    else $error("power-off wake event ignored");
  a_supply_loss:
    assert property (mode == M_OFF && !supplyOk |=> mode == M_NOPWR)
    else $error("supply loss not seen in power-off");
  a_nopwr_hold:
    assert property (mode == M_NOPWR && !supplyUp |=> mode == M_NOPWR)
    else $error("left not-powered without supply");
  a_idle_quiet:
    assert property (mode == M_IDLE |-> !ifaceAvail && !ctsOn && !fastClkSel)
    else $error("idle with interfaces or fast clock on");
  a_ps_cleared:
    assert property (switchOn |=> psSet == PS_DISABLED && mode == M_ACTIVE)
    else $error("power saving not cleared at switch-on");
  a_no_idle_off:
    assert property (psSet == PS_DISABLED |=> mode != M_IDLE || $past(inIdle))
    else $error("idle entered with power saving off");
  a_idle_wake:
    assert property (inIdle && supplyOk && anyWake |=> mode == M_ACTIVE)
    else $error("wake source did not leave idle");
  a_rts_wake:
    assert property (inIdle && supplyOk && wakeSrc[WK_RTS]
                     |=> mode == M_ACTIVE && ifaceAvail)
    else $error("rts wake failed");
  a_call_start:
    assert property (mode == M_ACTIVE && supplyOk && cmdCallOn && !cmdOff
                     |=> mode == M_CONN)
    else $error("call start did not enter connected");
  a_call_end:
    assert property (mode == M_CONN && supplyOk && cmdCallEnd
                     |=> mode == M_ACTIVE)
    else $error("call end did not return to active");
  a_switch_on:
    assert property (mode == M_NOPWR && supplyUp |=> mode == M_ACTIVE)
    else $error("supply rise did not reach active");
  a_idle_entry:
    assert property (mode == M_ACTIVE && supplyOk && idleGo |=> mode == M_IDLE)
    else $error("quiet active with saving on did not idle");
  a_live_avail:
    assert property ((mode == M_ACTIVE || mode == M_CONN) &&
                     $past(psSet) == PS_DISABLED |-> ifaceAvail && ctsOn)
    else $error("interfaces unavailable with saving off");
  a_fast_clock:
    assert property (fastClkSel == (mode == M_ACTIVE || mode == M_CONN))
    else $error("clock reference does not follow mode");
  a_alarm_wake:
    assert property (inIdle && supplyOk && rtcAlarm |=> mode == M_ACTIVE)
    else $error("alarm did not leave idle");
  a_page_wake:
    assert property (inIdle && supplyOk && pageCnt == 16'h0 &&
                     psSet == PS_PERIODIC |=> mode == M_ACTIVE && ifaceAvail)
    else $error("periodic wake without uart");
  a_uart_wake:
    assert property (inIdle && supplyOk && pinFall[P_RXD] &&
                     psSet == PS_PERIODIC |=> mode == M_ACTIVE)
    else $error("uart activity did not leave idle");
  a_dtr_wake:
    assert property (inIdle && supplyOk && psSet == PS_DTR && pinRise[P_DTR]
                     |=> mode == M_ACTIVE && ifaceAvail)
    else $error("dtr wake failed");
  a_usb_wake:
    assert property (inIdle && supplyOk &&
                     (pinRise[P_USBDET] || pinRise[P_USBRW])
                     |=> mode == M_ACTIVE)
    else $error("usb event did not leave idle");
  a_aux_wake:
    assert property (inIdle && supplyOk && pinRise[P_AUX] |=> mode == M_ACTIVE)
    else $error("aux data-ready did not leave idle");
  a_bus_answer:
    assert property (busReq && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
endmodule : omc_mode_ctrl

// *** omc_host_model.sv ***
`timescale 1ns/10ps
module omc_host_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [5:0] kick,
  output logic uartRxd,
  output logic rtsOn,
  output logic dtrOn,
  output logic usbPresenceSense,
  output logic usbRemoteWake,
  output logic auxWakePin,
  output logic slowClockInput
);
  logic [5:0] pat;
  logic [3:0] hold;
  logic [3:0] slowDiv;
  // pins stay asserted 9 cycles (rxd held low) so the two-stage sync cannot miss them
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pat <= 6'h00;
      hold <= 4'h0;
      slowDiv <= 4'h0;
    end else begin
      slowDiv <= slowDiv + 4'h1;
      if (kick != 6'h00) begin
        pat <= kick;
        hold <= 4'h8;
      end else if (hold != 4'h0) begin
        hold <= hold - 4'h1;
      end else begin
        pat <= 6'h00;
      end
    end
  end
  assign uartRxd = ~pat[0];
  assign rtsOn = pat[1];
  assign dtrOn = pat[2];
  assign usbPresenceSense = pat[3];
  assign usbRemoteWake = pat[4];
  assign auxWakePin = pat[5];
  // free-running reference, never stops between uses
  assign slowClockInput = slowDiv[3];
endmodule : omc_host_model

// *** operating_mode_controller_tb.sv ***
`timescale 1ns/10ps
module operating_mode_controller_tb;
  import omc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic mainSupplyOk = 1'b0;
  logic switchOnLine = 1'b0;
  logic extReset_n = 1'b1;
  logic rtcAlarm = 1'b0;
  logic [5:0] kick = 6'h00;
  logic rtsOn, dtrOn, usbPresenceSense, usbRemoteWake, auxWakePin;
  logic slowClockInput, uartRxd, ifaceAvail, ctsOn, fastClkSel, rtcRun;
  omc_mode_t mode;
  logic [63:0] expQ[$];
  int fails = 0;
  int compares = 0;
  omc_host_model host (.core_clk(core_clk), .rst_n(rst_n), .kick(kick),
    .uartRxd(uartRxd), .rtsOn(rtsOn), .dtrOn(dtrOn),
    .usbPresenceSense(usbPresenceSense), .usbRemoteWake(usbRemoteWake),
    .auxWakePin(auxWakePin), .slowClockInput(slowClockInput));
  omc_mode_ctrl #(.INTERNAL_OSC(1'b0), .IDLE_HOLD(4)) uut (
    .core_clk(core_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mainSupplyOk(mainSupplyOk),
    .switchOnLine(switchOnLine), .extReset_n(extReset_n), .rtsOn(rtsOn),
    .dtrOn(dtrOn), .usbPresenceSense(usbPresenceSense),
    .usbRemoteWake(usbRemoteWake), .auxWakePin(auxWakePin),
    .slowClockInput(slowClockInput), .uartRxd(uartRxd), .rtcAlarm(rtcAlarm),
    .mode(mode), .ifaceAvail(ifaceAvail), .ctsOn(ctsOn),
    .fastClkSel(fastClkSel), .rtcRun(rtcRun));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  task busXfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 50) fails++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : busXfer
  task busRd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back({e, m});
    busXfer(1'b0, a, 32'h0);
  endtask : busRd
  task waitMode(input omc_mode_t m, input int lim);
    int n;
    n = 0;
    while (mode !== m && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    compares++;
    if (mode !== m) begin
      $display("FAIL mode expected %0h seen %0h", m, mode);
      fails++;
    end
  endtask : waitMode
  task pulse(input int which);
    if (which == 0) switchOnLine <= 1'b1;
    if (which == 1) extReset_n <= 1'b0;
    if (which == 2) rtcAlarm <= 1'b1;
    @(posedge core_clk);
    rtcAlarm <= 1'b0;
    repeat (5) @(posedge core_clk);
    switchOnLine <= 1'b0;
    extReset_n <= 1'b1;
    @(posedge core_clk);
  endtask : pulse
  // read answers are matched in order against the notes queued by busRd
  always @(posedge core_clk) begin
    logic [63:0] e;
    if (avs_read && avs_waitrequest === 1'b0) begin
      e = (expQ.size() > 0) ? expQ.pop_front() : 64'hFFFFFFFF_FFFFFFFF;
      compares++;
      if ((avs_readdata & e[31:0]) !== e[63:32]) begin
        $display("FAIL readdata expected %h seen %h", e[63:32], avs_readdata);
        fails++;
      end
    end
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    fails++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(62));
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    pulse(0);
    pulse(2);
    waitMode(M_NOPWR, 1);
    mainSupplyOk <= 1'b1;
    waitMode(M_ACTIVE, 20);
    @(posedge core_clk);
    busRd(OFS_STATUS, 32'h39, 32'h3F);
    busRd(4'h2, 32'h0, 32'hFFFFFFFF);
    busRd(OFS_CMD, 32'h0, 32'hFFFFFFFF);
    busXfer(1'b1, OFS_CMD, 32'h4);
    busRd(OFS_STATUS, 32'h39, 32'h3F);
    busXfer(1'b1, OFS_CMD, 32'h2);
    busRd(OFS_STATUS, 32'h3B, 32'h3F);
    busXfer(1'b1, OFS_CMD, 32'h4);
    busRd(OFS_STATUS, 32'h39, 32'h3F);
    for (int i = 0; i < 3; i++) begin
      busXfer(1'b1, OFS_CTRL, (i == 0) ? 32'h1 : 32'h0);
      busXfer(1'b1, OFS_CMD, 32'h1);
      waitMode(M_OFF, 20);
      busRd(OFS_STATUS, 32'h04, 32'h3F);
      pulse(i);
      waitMode(M_ACTIVE, 20);
      @(posedge core_clk);
      if (i == 0) busRd(OFS_CTRL, 32'h0, 32'h3);
    end
    busXfer(1'b1, OFS_CMD, 32'h1);
    waitMode(M_OFF, 20);
    mainSupplyOk <= 1'b0;
    waitMode(M_NOPWR, 20);
    mainSupplyOk <= 1'b1;
    waitMode(M_ACTIVE, 20);
    @(posedge core_clk);
    // one idle entry per wake source; paging kept far off except case 0
    for (int k = 0; k < WK_N; k++) begin
      busXfer(1'b1, OFS_PAGE,
        (k == 0) ? 32'h10 + $urandom_range(31, 0) : 32'hFFFF);
      busXfer(1'b1, OFS_CTRL, (k == 3) ? 32'hE : (k == 4) ? 32'h3 : 32'h1);
      waitMode(M_IDLE, 100);
      compares++;
      if ({ifaceAvail, ctsOn, fastClkSel} !== 3'b000) begin
        $display("FAIL idle outputs expected 0 seen %b",
          {ifaceAvail, ctsOn, fastClkSel});
        fails++;
      end
      repeat ($urandom_range(3, 0)) @(posedge core_clk);
      // one-edge alarm; a long pulse would hold off the next idle entry
      if (k == 1) rtcAlarm <= 1'b1;
      if (k >= 2) kick <= 6'h01 << (k - 2);
      @(posedge core_clk);
      kick <= 6'h00;
      rtcAlarm <= 1'b0;
      waitMode(M_ACTIVE, 80);
      busRd(OFS_STATUS, 32'h39 | (32'h1 << (8 + k)), 32'hFF3F);
    end
    busXfer(1'b1, OFS_CTRL, 32'h0);
    compares++;
    if (rtcRun !== 1'b1) begin
      $display("FAIL rtcRun expected 1 seen %b", rtcRun);
      fails++;
    end
    results();
  end
endmodule : operating_mode_controller_tb
